// ---- hw/quad_counter_pkg.sv ----
package quad_counter_pkg;

	// ---------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ---------------------------------------------------------------
	localparam logic [7:0]  IDX_CNT_A      = 8'h58;
	localparam logic [7:0]  IDX_CNT_B      = 8'h59;
	localparam logic [7:0]  IDX_CNT_C      = 8'h5A;
	localparam logic [7:0]  IDX_CNT_D      = 8'h5B;
	localparam logic [7:0]  IDX_CLOCK_SEL  = 8'h5C;
	localparam logic [7:0]  IDX_CONFIG_PRI = 8'h5D;
	localparam logic [7:0]  IDX_CONFIG_SEC = 8'h5E;
	localparam logic [7:0]  IDX_RUN        = 8'h5F;
	localparam logic [7:0]  REG_RESET      = 8'h00;
	localparam logic [15:0] CNT_RESET      = 16'h0000;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int DIR_BASE_POS   = 4;
	localparam int JOIN_CD_POS    = 3;
	localparam int JOIN_AB_POS    = 2;
	localparam int PWM_SECOND_POS = 1;
	localparam int PWM_FIRST_POS  = 0;
	localparam int CAP_SRC_POS    = 6;
	localparam int CAP_FN_POS     = 4;
	localparam int RES_SECOND_POS = 2;
	localparam int RES_FIRST_POS  = 0;
	localparam int HALVE_BASE_POS = 4;
	localparam int RUN_BASE_POS   = 0;

	// ---------------------------------------------------------------
	// Codes and counts
	// ---------------------------------------------------------------
	localparam logic [1:0] CK_PIN      = 2'h0;
	localparam logic [1:0] CK_FAST     = 2'h1;
	localparam logic [1:0] CK_SLOW     = 2'h2;
	localparam logic [1:0] CK_TICK128  = 2'h3;
	localparam logic [1:0] RC_QUARTER  = 2'h3;
	localparam logic [1:0] CAP_OFF     = 2'h0;
	localparam logic [1:0] CAP_LOWRATE = 2'h0;
	localparam logic [1:0] CAP_INTERN  = 2'h1;
	localparam logic [15:0] RES_MASK_8 = 16'h00FF;
	localparam logic [15:0] RES_FULL   = 16'hFFFF;

	typedef struct packed {
		logic       joined;
		logic       upLo;
		logic       upHi;
		logic       runLo;
		logic       runHi;
		logic       pwmOn;
		logic [1:0] res;
	} pair_cfg_t;

	typedef struct packed {
		logic tickLo;
		logic tickHi;
		logic loadLo;
		logic loadHi;
	} pair_strobe_t;

endpackage

// ---- hw/counter_pair.sv ----
`timescale 1ns/1ps
module counter_pair
	import quad_counter_pkg::*;
(
	input  wire logic         clock,  // System clock
	input  wire logic         reset,  // Sync reset, high
	input  wire pair_cfg_t    cfg,    // Pair configuration
	input  wire pair_strobe_t stb,    // Ticks and loads
	input  wire logic [15:0]  cmp,    // Compare {hi, lo}
	output logic      [15:0]  count,  // Live count {hi, lo}
	output logic      [1:0]   match,  // Wrap pulses {hi, lo}
	output logic              pwmOut  // Pulse output level
);

	logic [15:0] cnt_q, cnt_d, mask;
	logic [1:0]  match_q, match_d;
	logic        pwm_q, pwm_d;
	logic [16:0] lo, hi, wide;

	// Returns {wrapped, next count}
	function automatic logic [16:0] stepCnt(input logic [15:0] c, m, msk,
		input logic up, pwm);
		if (pwm)
			return {(c & msk) == msk, (c + 16'h0001) & msk};
		else if (up)
			return (c == m) ? {1'b1, 16'h0000}
				: {1'b0, (c + 16'h0001) & msk};
		else
			return (c == 16'h0000) ? {1'b1, m}
				: {1'b0, (c - 16'h0001) & msk};
	endfunction

	// Wider resolutions exist only on a joined pair
	function automatic logic [15:0] resMask(input logic [1:0] r,
		input logic j);
		if (!j)
			return RES_MASK_8;
		return RES_FULL >> (4'h6 - {1'b0, r, 1'b0});
	endfunction

	always_comb begin
		mask = resMask(cfg.res, cfg.joined);
		cnt_d = cnt_q;
		match_d = 2'b00;
		lo = stepCnt({8'h00, cnt_q[7:0]}, {8'h00, cmp[7:0]}, RES_MASK_8,
			cfg.upLo, cfg.pwmOn);
		hi = stepCnt({8'h00, cnt_q[15:8]}, {8'h00, cmp[15:8]}, RES_MASK_8,
			cfg.upHi, 1'b0);
		// Plain counting uses all 16 bits; the size code shapes PWM only
		wide = stepCnt(cnt_q, cmp, cfg.pwmOn ? mask : RES_FULL,
			cfg.upLo, cfg.pwmOn);
		if (cfg.joined) begin
			if (stb.loadLo | stb.loadHi) begin
				cnt_d = cfg.upLo ? CNT_RESET : cmp;
			end else if (cfg.runHi & stb.tickLo) begin
				cnt_d = wide[15:0];
				match_d[0] = wide[16];
			end
		end else begin
			if (stb.loadLo) begin
				cnt_d[7:0] = cfg.upLo ? 8'h00 : cmp[7:0];
			end else if (cfg.runLo & stb.tickLo) begin
				cnt_d[7:0] = lo[7:0];
				match_d[0] = lo[16];
			end
			if (stb.loadHi) begin
				cnt_d[15:8] = cfg.upHi ? 8'h00 : cmp[15:8];
			end else if (cfg.runHi & stb.tickHi) begin
				cnt_d[15:8] = hi[7:0];
				match_d[1] = hi[16];
			end
		end
		pwm_d = cfg.pwmOn & ((cnt_q & mask) < (cmp & mask));
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			cnt_q <= CNT_RESET;
			match_q <= 2'b00;
			pwm_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			match_q <= match_d;
			pwm_q <= pwm_d;
		end
	end

	assign count = cnt_q;
	assign match = match_q;
	assign pwmOut = pwm_q;

	AST_STOPPED_HOLDS: assert property (@(posedge clock) disable iff (reset)
		!cfg.joined && !cfg.runLo && !stb.loadLo
		|=> cnt_q[7:0] == $past(cnt_q[7:0]))
		else $error("stopped counter moved");

	AST_PWM_LEVEL: assert property (@(posedge clock) disable iff (reset)
		!cfg.pwmOn |=> !pwm_q)
		else $error("pulse output high while disabled");

	AST_DOWN_RELOAD: assert property (@(posedge clock) disable iff (reset)
		!cfg.joined && cfg.runLo && stb.tickLo && !stb.loadLo && !cfg.pwmOn
		&& !cfg.upLo && cnt_q[7:0] == 8'h00
		|=> cnt_q[7:0] == $past(cmp[7:0]) && match_q[0])
		else $error("down count did not reload");

endmodule

// ---- hw/quad_counter_timer_pwm.sv ----
// Our own choice: the APB slave port.
`timescale 1ns/1ps
// Summary of operation
// - four 8-bit counters, pairable into 16-bit
// - direction bit 1 counts up, 0 down
// - join bits pair C+D and A+B
// - PWM enable bits for C and A paths
// - PWM resolution fields pick output width of a joined pair
// - capture on chosen edges; 32k rising only
// - capture source and function fields select trigger
// - two-bit clock choice per counter
// - port pins 0-3 serve as counter clocks
// - halving bit divides external clock by two
// - counter runs only while enabled
// - A/B write compare; read count or capture
// - C/D write compare; read live count
// - counters raise interrupts and events
// - clock code map: pin, fast, slow, 128 Hz
// - counter-mode write clears or loads count
// - PWM/capture-mode write leaves count alone
module quad_counter_timer_pwm
	import quad_counter_pkg::*;
(
	input  wire logic        clock,                   // 100 MHz
	input  wire logic        reset,                   // Sync, high
	input  wire logic        psel,                    // APB select
	input  wire logic        penable,                 // APB enable
	input  wire logic        pwrite,                  // APB write
	input  wire logic [11:0] paddr,                   // APB address
	input  wire logic [31:0] pwdata,                  // APB write data
	output logic      [31:0] prdata,                  // APB read data
	output logic             pready,                  // APB ready
	output logic             pslverr,                 // APB error
	input  wire logic [3:0]  inputPortOne,            // Pin clocks
	input  wire logic        rcOscillatorClock,       // RC clock
	input  wire logic        lowRatePrescalerClock,   // 32 kHz
	input  wire logic        kilohertzPrescalerClock, // 1 kHz
	input  wire logic        tick128Hz,               // 128 Hz timer
	input  wire logic        captureInternal,         // Internal trig
	input  wire logic        captureExternal,         // External trig
	output logic      [1:0]  pulseOut,                // PWM levels
	output logic      [1:0]  pulseActive,             // PWM overrides
	output logic      [3:0]  counterIrq,              // IRQ pulses
	output logic      [3:0]  counterEvent             // Event pulses
);

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	function automatic logic isMapped(input logic [11:0] a);
		return a[11:10] == 2'b00 && a[1:0] == 2'b00
			&& a[9:2] >= IDX_CNT_A && a[9:2] <= IDX_RUN;
	endfunction

	logic [7:0]      idx;
	logic            hit, wrEn, rdSetup;
	logic [3:0][7:0] counterValue_q, counterValue_d;
	logic [7:0]      clockSelect_q, clockSelect_d;
	logic [7:0]      configPrimary_q, configPrimary_d;
	logic [7:0]      configSecondary_q, configSecondary_d;
	logic [7:0]      runControl_q, runControl_d;
	logic [31:0]     prdata_q, prdata_d;
	logic [3:0]      load_q, load_d;

	assign idx = paddr[9:2];
	assign hit = isMapped(paddr);
	assign wrEn = psel & penable & pwrite;
	assign rdSetup = psel & ~penable & ~pwrite;
	// Read data is captured in setup, so no wait states are needed
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign prdata = prdata_q;

	// ---------------------------------------------------------------
	// Mode decode
	// ---------------------------------------------------------------
	logic [3:0] dirBits, runBits, halveBits;
	logic       joinAB, joinCD, pwmFirst, pwmSecond, capActive;
	logic [1:0] capSrc, capFn;
	logic [3:0] counterMode;

	assign dirBits = configPrimary_q[DIR_BASE_POS +: 4];
	assign joinAB = configPrimary_q[JOIN_AB_POS];
	assign joinCD = configPrimary_q[JOIN_CD_POS];
	assign pwmFirst = configPrimary_q[PWM_FIRST_POS];
	assign pwmSecond = configPrimary_q[PWM_SECOND_POS];
	assign capSrc = configSecondary_q[CAP_SRC_POS +: 2];
	assign capFn = configSecondary_q[CAP_FN_POS +: 2];
	assign capActive = capFn != CAP_OFF;
	assign runBits = runControl_q[RUN_BASE_POS +: 4];
	assign halveBits = runControl_q[HALVE_BASE_POS +: 4];
	// Plain counting only; PWM or capture keeps the count on write
	assign counterMode[0] = ~pwmFirst & ~capActive;
	assign counterMode[1] = ~(pwmFirst & joinAB) & ~capActive;
	assign counterMode[2] = ~pwmSecond;
	assign counterMode[3] = ~(pwmSecond & joinCD);

	// ---------------------------------------------------------------
	// Register file
	// ---------------------------------------------------------------
	always_comb begin
		counterValue_d = counterValue_q;
		clockSelect_d = clockSelect_q;
		configPrimary_d = configPrimary_q;
		configSecondary_d = configSecondary_q;
		runControl_d = runControl_q;
		load_d = 4'h0;
		if (wrEn && hit) begin
			case (idx)
				IDX_CNT_A, IDX_CNT_B, IDX_CNT_C, IDX_CNT_D: begin
					counterValue_d[idx[1:0]] = pwdata[7:0];
					load_d[idx[1:0]] = counterMode[idx[1:0]];
				end
				IDX_CLOCK_SEL:  clockSelect_d = pwdata[7:0];
				IDX_CONFIG_PRI: configPrimary_d = pwdata[7:0];
				IDX_CONFIG_SEC: configSecondary_d = pwdata[7:0];
				IDX_RUN:        runControl_d = pwdata[7:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			counterValue_q <= {4{REG_RESET}};
			clockSelect_q <= REG_RESET;
			configPrimary_q <= REG_RESET;
			configSecondary_q <= REG_RESET;
			runControl_q <= REG_RESET;
			load_q <= 4'h0;
		end else begin
			counterValue_q <= counterValue_d;
			clockSelect_q <= clockSelect_d;
			configPrimary_q <= configPrimary_d;
			configSecondary_q <= configSecondary_d;
			runControl_q <= runControl_d;
			load_q <= load_d;
		end
	end

	// ---------------------------------------------------------------
	// Clock sources as enable pulses
	// ---------------------------------------------------------------
	// Sources are sampled levels; rising edges become one-cycle ticks
	logic [8:0] srcNow, src_q, srcRise, srcFall;
	logic [1:0] rcQuarter_q, rcQuarter_d;
	logic [3:0] halve_q, halve_d, pinTick, tick;
	logic       captureSig, rcQuarterTick;

	function automatic logic pickTick(input logic [1:0] code,
		input logic pin, fast, slow, t128);
		case (code)
			CK_PIN:     return pin;
			CK_FAST:    return fast;
			CK_SLOW:    return slow;
			CK_TICK128: return t128;
			default:    return 1'b0;
		endcase
	endfunction

	always_comb begin
		case (capSrc)
			CAP_LOWRATE: captureSig = lowRatePrescalerClock;
			CAP_INTERN:  captureSig = captureInternal;
			default:     captureSig = captureExternal;
		endcase
		srcNow = {captureSig, tick128Hz, kilohertzPrescalerClock,
			lowRatePrescalerClock, rcOscillatorClock, inputPortOne};
		srcRise = srcNow & ~src_q;
		srcFall = ~srcNow & src_q;
		rcQuarterTick = srcRise[4] & (rcQuarter_q == RC_QUARTER);
		rcQuarter_d = srcRise[4] ? rcQuarter_q + 2'h1 : rcQuarter_q;
		halve_d = halve_q ^ srcRise[3:0];
		pinTick = srcRise[3:0] & (~halveBits | halve_q);
		for (int i = 0; i < 2; i++) begin
			tick[i] = pickTick(clockSelect_q[2*i +: 2], pinTick[i],
				srcRise[4], rcQuarterTick, srcRise[7]);
			tick[i+2] = pickTick(clockSelect_q[2*i+4 +: 2], pinTick[i+2],
				srcRise[5], srcRise[6], srcRise[7]);
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			src_q <= 9'h000;
			rcQuarter_q <= 2'h0;
			halve_q <= 4'h0;
		end else begin
			src_q <= srcNow;
			rcQuarter_q <= rcQuarter_d;
			halve_q <= halve_d;
		end
	end

	// ---------------------------------------------------------------
	// Counter pairs
	// ---------------------------------------------------------------
	pair_cfg_t    cfgAB, cfgCD;
	pair_strobe_t stbAB, stbCD;
	logic [15:0]  countAB, countCD;
	logic [1:0]   matchAB, matchCD;

	always_comb begin
		cfgAB = '{joined: joinAB, upLo: dirBits[0], upHi: dirBits[1],
			runLo: runBits[0], runHi: runBits[1], pwmOn: pwmFirst,
			res: configSecondary_q[RES_FIRST_POS +: 2]};
		cfgCD = '{joined: joinCD, upLo: dirBits[2], upHi: dirBits[3],
			runLo: runBits[2], runHi: runBits[3], pwmOn: pwmSecond,
			res: configSecondary_q[RES_SECOND_POS +: 2]};
		stbAB = '{tickLo: tick[0], tickHi: tick[1],
			loadLo: load_q[0], loadHi: load_q[1]};
		stbCD = '{tickLo: tick[2], tickHi: tick[3],
			loadLo: load_q[2], loadHi: load_q[3]};
	end

	counter_pair pairAB (
		.clock  (clock),
		.reset  (reset),
		.cfg    (cfgAB),
		.stb    (stbAB),
		.cmp    ({counterValue_q[1], counterValue_q[0]}),
		.count  (countAB),
		.match  (matchAB),
		.pwmOut (pulseOut[0])
	);

	counter_pair pairCD (
		.clock  (clock),
		.reset  (reset),
		.cfg    (cfgCD),
		.stb    (stbCD),
		.cmp    ({counterValue_q[3], counterValue_q[2]}),
		.count  (countCD),
		.match  (matchCD),
		.pwmOut (pulseOut[1])
	);

	assign pulseActive = {pwmSecond, pwmFirst};

	// ---------------------------------------------------------------
	// Capture and interrupts
	// ---------------------------------------------------------------
	logic [15:0] capture_q, capture_d;
	logic [3:0]  irq_q, irq_d;
	logic        capEdge;

	always_comb begin
		// Low-rate source only ever triggers on its rising edge
		if (capSrc == CAP_LOWRATE)
			capEdge = capActive & srcRise[8];
		else
			capEdge = capActive & ((capFn[0] & srcRise[8])
				| (capFn[1] & srcFall[8]));
		capture_d = capEdge ? countAB : capture_q;
		irq_d[0] = capActive ? capEdge : (~pwmFirst & matchAB[0]);
		irq_d[1] = capActive ? capEdge : (~joinAB & matchAB[1]);
		irq_d[2] = ~pwmSecond & matchCD[0];
		irq_d[3] = ~joinCD & matchCD[1];
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			capture_q <= CNT_RESET;
			irq_q <= 4'h0;
		end else begin
			capture_q <= capture_d;
			irq_q <= irq_d;
		end
	end

	assign counterIrq = irq_q;
	assign counterEvent = irq_q;

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	always_comb begin
		prdata_d = prdata_q;
		if (rdSetup) begin
			prdata_d = 32'h0000_0000;
			case (idx)
				IDX_CNT_A: prdata_d[7:0] = capActive ? capture_q[7:0]
					: countAB[7:0];
				IDX_CNT_B: prdata_d[7:0] = capActive ? capture_q[15:8]
					: countAB[15:8];
				IDX_CNT_C:      prdata_d[7:0] = countCD[7:0];
				IDX_CNT_D:      prdata_d[7:0] = countCD[15:8];
				IDX_CLOCK_SEL:  prdata_d[7:0] = clockSelect_q;
				IDX_CONFIG_PRI: prdata_d[7:0] = configPrimary_q;
				IDX_CONFIG_SEC: prdata_d[7:0] = configSecondary_q;
				IDX_RUN:        prdata_d[7:0] = runControl_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (reset)
			prdata_q <= 32'h0000_0000;
		else
			prdata_q <= prdata_d;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence downWriteA;
		wrEn && hit && idx == IDX_CNT_A && counterMode[0]
		&& !dirBits[0] && !joinAB;
	endsequence

	sequence upWriteC;
		wrEn && hit && idx == IDX_CNT_C && counterMode[2]
		&& dirBits[2] && !joinCD;
	endsequence

	AST_DOWN_WRITE_LOADS: assert property (@(posedge clock)
		disable iff (reset)
		downWriteA |=> ##1 countAB[7:0] == $past(pwdata[7:0], 2))
		else $error("down-count write did not load compare");

	AST_UP_WRITE_CLEARS: assert property (@(posedge clock)
		disable iff (reset)
		upWriteC |=> ##1 countCD[7:0] == 8'h00)
		else $error("up-count write did not clear count");

	AST_PWM_WRITE_KEEPS: assert property (@(posedge clock)
		disable iff (reset)
		wrEn && hit && idx == IDX_CNT_A && pwmFirst |=> load_q == 4'h0)
		else $error("write in pulse mode touched count");

	AST_CAPTURE_LATCH: assert property (@(posedge clock)
		disable iff (reset)
		capEdge |=> capture_q == $past(countAB) && irq_q[0] && irq_q[1])
		else $error("capture did not latch count");

	AST_UNMAPPED_ERR: assert property (@(posedge clock)
		disable iff (reset)
		psel && penable && !hit |-> pslverr)
		else $error("unmapped access without error");

endmodule

// ---- testbench/quad_counter_timer_pwm_tb.sv ----
`timescale 1ns/1ps
module quad_counter_timer_pwm_tb;
	import quad_counter_pkg::*;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        clock;
	logic        reset;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [7:0]  srcTick;
	logic        captureInternal;
	logic        captureExternal;
	logic [1:0]  pulseOut;
	logic [1:0]  pulseActive;
	logic [3:0]  counterIrq;
	logic [3:0]  counterEvent;
	logic        lastErr;
	int          errors;
	int          checks;
	int          irqCnt [4];
	int          evBad;

	quad_counter_timer_pwm i_quad_counter_timer_pwm (
		.clock                   (clock),
		.reset                   (reset),
		.psel                    (psel),
		.penable                 (penable),
		.pwrite                  (pwrite),
		.paddr                   (paddr),
		.pwdata                  (pwdata),
		.prdata                  (prdata),
		.pready                  (pready),
		.pslverr                 (pslverr),
		.inputPortOne            (srcTick[3:0]),
		.rcOscillatorClock       (srcTick[4]),
		.lowRatePrescalerClock   (srcTick[5]),
		.kilohertzPrescalerClock (srcTick[6]),
		.tick128Hz               (srcTick[7]),
		.captureInternal         (captureInternal),
		.captureExternal         (captureExternal),
		.pulseOut                (pulseOut),
		.pulseActive             (pulseActive),
		.counterIrq              (counterIrq),
		.counterEvent            (counterEvent)
	);

	always #5 clock = ~clock;

	always @(posedge clock) begin
		if (reset) begin
			irqCnt <= '{default: 0};
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (counterIrq[i] === 1'b1) begin
					irqCnt[i] <= irqCnt[i] + 1;
				end
			end
			if (counterEvent !== counterIrq) begin
				evBad <= evBad + 1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic end_sim();
		$display("Comparisons %0d, mismatches %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic do_reset();
		@(posedge clock) reset <= 1'b1;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
	endtask

	// Holds the whole request until pready is seen high at an edge
	task automatic apb(input logic w, input logic [7:0] idx,
			input logic [7:0] wd, output logic [31:0] rd);
		@(posedge clock);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h000000, wd};
		@(posedge clock) penable <= 1'b1;
		// Only the watchdog ends a wait for pready
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd      = prdata;
		lastErr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		logic [31:0] rd;
		apb(1'b1, idx, wd, rd);
		repeat (2) @(posedge clock);
	endtask

	task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] rd;
		apb(1'b0, idx, 8'h00, rd);
		chk(rd, {24'h000000, exp});
	endtask

	// Source index: 0..3 pins, 4 rc, 5 low rate, 6 kHz, 7 128 Hz
	task automatic ticks(input int k, input int n);
		repeat (n) begin
			@(posedge clock) srcTick[k] <= 1'b1;
			@(posedge clock) srcTick[k] <= 1'b0;
		end
		repeat (4) @(posedge clock);
	endtask

	// Window of one full period while ticking every two cycles
	task automatic pwm_duty(input int k, input int ch, input int per,
			input int exp);
		int hi;
		hi = 0;
		fork
			ticks(k, per / 2 + 30);
			begin
				repeat (20) @(posedge clock);
				repeat (per) begin
					@(posedge clock);
					if (pulseOut[ch] === 1'b1) hi++;
				end
			end
		join
		chk(hi, exp);
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic s_regs();
		logic [31:0] rd;
		for (int i = 0; i < 4; i++) begin
			wr(IDX_CLOCK_SEL + i, 8'hA5 + i);
			rdchk(IDX_CLOCK_SEL + i, 8'hA5 + i);
		end
		do_reset();
		for (int i = 0; i < 8; i++) rdchk(IDX_CNT_A + i, 8'h00);
		chk(lastErr, 1'b0);
		apb(1'b0, 8'h60, 8'h00, rd);
		chk({31'h0, lastErr}, 32'h1);
		chk(rd, 32'h0);
	endtask

	task automatic s_up_wrap();
		do_reset();
		wr(IDX_CONFIG_PRI, 8'h10);
		wr(IDX_CNT_A, 8'h03);
		wr(IDX_RUN, 8'h01);
		ticks(0, 3);
		rdchk(IDX_CNT_A, 8'h03);
		ticks(0, 1);
		rdchk(IDX_CNT_A, 8'h00);
		chk(irqCnt[0], 1);
		wr(IDX_RUN, 8'h00);
		ticks(0, 2);
		rdchk(IDX_CNT_A, 8'h00);
	endtask

	task automatic s_down();
		do_reset();
		wr(IDX_CNT_A, 8'h01);
		rdchk(IDX_CNT_A, 8'h01);
		wr(IDX_CNT_B, 8'h05);
		rdchk(IDX_CNT_B, 8'h05);
		wr(IDX_RUN, 8'h03);
		ticks(1, 2);
		rdchk(IDX_CNT_B, 8'h03);
		ticks(1, 4);
		rdchk(IDX_CNT_B, 8'h05);
		chk(irqCnt[1], 1);
		ticks(0, 2);
		rdchk(IDX_CNT_A, 8'h01);
		chk(irqCnt[0], 1);
	endtask

	task automatic s_internal();
		do_reset();
		wr(IDX_CLOCK_SEL, 8'hE9);
		wr(IDX_CONFIG_PRI, 8'hF0);
		for (int i = 0; i < 4; i++) wr(IDX_CNT_A + i, 8'hFF);
		wr(IDX_RUN, 8'h0F);
		ticks(4, 8);
		ticks(6, 3);
		ticks(7, 3);
		ticks(5, 2);
		rdchk(IDX_CNT_A, 8'h08);
		rdchk(IDX_CNT_B, 8'h02);
		rdchk(IDX_CNT_C, 8'h03);
		rdchk(IDX_CNT_D, 8'h03);
	endtask

	task automatic s_halve();
		do_reset();
		wr(IDX_CONFIG_PRI, 8'h10);
		wr(IDX_CNT_A, 8'hFF);
		wr(IDX_RUN, 8'h11);
		ticks(0, 4);
		rdchk(IDX_CNT_A, 8'h02);
	endtask

	task automatic s_cascade();
		do_reset();
		wr(IDX_CONFIG_PRI, 8'h14);
		wr(IDX_CLOCK_SEL, 8'h01);
		wr(IDX_CNT_B, 8'hFF);
		wr(IDX_CNT_A, 8'hFF);
		wr(IDX_RUN, 8'h02);
		ticks(4, 300);
		wr(IDX_RUN, 8'h00);
		rdchk(IDX_CNT_A, 8'h2C);
		rdchk(IDX_CNT_B, 8'h01);
	endtask

	task automatic s_capture();
		do_reset();
		wr(IDX_CONFIG_PRI, 8'h10);
		wr(IDX_CNT_A, 8'hFF);
		wr(IDX_CONFIG_SEC, 8'h50);
		wr(IDX_RUN, 8'h01);
		ticks(0, 5);
		@(posedge clock) captureInternal <= 1'b1;
		repeat (4) @(posedge clock);
		ticks(0, 3);
		rdchk(IDX_CNT_A, 8'h05);
		chk(irqCnt[0], 1);
		// External source, falling edge only: the rise must not latch
		wr(IDX_CONFIG_SEC, 8'hA0);
		@(posedge clock) captureExternal <= 1'b1;
		ticks(0, 2);
		captureExternal <= 1'b0;
		ticks(0, 1);
		rdchk(IDX_CNT_A, 8'h0A);
		captureInternal <= 1'b0;
	endtask

	task automatic s_pwm();
		do_reset();
		wr(IDX_CONFIG_PRI, 8'h03);
		wr(IDX_CLOCK_SEL, 8'h11);
		wr(IDX_CNT_A, 8'h40);
		wr(IDX_CNT_C, 8'hC0);
		rdchk(IDX_CNT_A, 8'h00);
		wr(IDX_RUN, 8'h05);
		chk(pulseActive, 2'b11);
		pwm_duty(4, 0, 512, 128);
		pwm_duty(5, 1, 512, 384);
		do_reset();
		wr(IDX_CONFIG_PRI, 8'h05);
		wr(IDX_CLOCK_SEL, 8'h01);
		wr(IDX_CNT_B, 8'h02);
		wr(IDX_CNT_A, 8'h00);
		wr(IDX_RUN, 8'h02);
		pwm_duty(4, 0, 2048, 1024);
	endtask

	// ---------------------------------------------------------------
	// Main sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		clock           = 1'b0;
		reset           = 1'b1;
		psel            = 1'b0;
		penable         = 1'b0;
		pwrite          = 1'b0;
		paddr           = 12'h000;
		pwdata          = 32'h00000000;
		srcTick         = 8'h00;
		captureInternal = 1'b0;
		captureExternal = 1'b0;
		errors          = 0;
		checks          = 0;
		evBad           = 0;
		do_reset();
		s_regs();
		s_up_wrap();
		s_down();
		s_internal();
		s_halve();
		s_cascade();
		s_capture();
		s_pwm();
		chk(evBad, 0);
		end_sim();
	end

	// Run is about 4.5k cycles; this leaves ample margin
	initial begin
		#400000;
		errors++;
		end_sim();
	end
endmodule
